// file: src/lcf_pkg.sv
// Package: register map, field layout, timing tables and carrier types
package lcf_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_OFS       = 8'h00;
    localparam logic [7:0] RETRY_OFS     = 8'h04;
    localparam logic [7:0] STATUS_OFS    = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h10;

    // ------------------------------------------------------------------
    // Reset values and control bit positions
    // ------------------------------------------------------------------
    localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
    localparam logic [2:0]  RETRY_RESET  = 3'h0;
    localparam logic [2:0]  IRQ_RESET    = 3'h0;
    localparam int          FAULT_CLR_BIT = 8;

    // Response modes: below 8 all act on the stage, 9 and up are off
    localparam logic [3:0] MODE_FIRST_RETRY = 4'h4;
    localparam logic [3:0] MODE_HS_RETRY    = 4'h6;
    localparam logic [3:0] MODE_REPORT      = 4'h8;
    localparam logic [1:0] ACT_TRISTATE     = 2'h0;
    localparam logic [1:0] ACT_RECIRC       = 2'h1;
    localparam logic [1:0] ACT_HS_BRAKE     = 2'h2;
    localparam logic [1:0] ACT_LS_BRAKE     = 2'h3;

    // ------------------------------------------------------------------
    // Timing: one base tick of 50 us at a 10 ns clock
    // ------------------------------------------------------------------
    localparam int TICK_NS       = 50000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TW            = 20;

    // Filter times 0.05 ms .. 1000 ms, in 50 us ticks
    localparam logic [TW-1:0] DEG_TICKS [16] = '{
        20'h00001, 20'h00002, 20'h00004, 20'h0000a,
        20'h00014, 20'h00032, 20'h00064, 20'h00096,
        20'h000c8, 20'h001f4, 20'h003e8, 20'h005dc,
        20'h007d0, 20'h00fa0, 20'h02710, 20'h04e20};

    // Retry waits 100 ms, 500 ms, 1 s .. 14 s, in 50 us ticks
    localparam logic [TW-1:0] RETRY_TICKS [16] = '{
        20'h007d0, 20'h02710, 20'h04e20, 20'h09c40,
        20'h0ea60, 20'h13880, 20'h186a0, 20'h1d4c0,
        20'h222e0, 20'h27100, 20'h2bf20, 20'h30d40,
        20'h35b60, 20'h3a980, 20'h3f7a0, 20'h445c0};

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       parity;
        logic [3:0] torque_ref;
        logic [3:0] comparator_lock_current_limit;
        logic [3:0] converter_lock_current_limit;
        logic [3:0] response_mode;
        logic [3:0] lock_current_filter_time;
        logic [3:0] lock_retry_wait;
        logic [6:0] other_fields;
    } lcf_cfg_type;

    typedef struct packed {
        logic       tristate;
        logic       recirc;
        logic [2:0] hs_on;
        logic [2:0] ls_on;
    } lcf_gate_type;

    typedef struct packed {
        logic retry_cleared;
        logic fault_latched;
        logic lock_detected;
    } lcf_event_type;

endpackage

// file: src/lcf_tick.sv
// Module: restartable divider giving a one-cycle tick enable
module lcf_tick #(
    parameter int DIV = 5000
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RESETN,
    // Control and output
    input  wire logic restart,
    output logic      tick
);

    logic [31:0] cnt_r;

    // Restart keeps the first tick a full period after the restart
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            cnt_r <= 32'h0;
        else if (restart || cnt_r == 32'(DIV - 1))
            cnt_r <= 32'h0;
        else
            cnt_r <= cnt_r + 32'h1;
    end

    assign tick = !restart && cnt_r == 32'(DIV - 1);

endmodule

// file: src/lcf_top.sv
// Module: lock current fault detection, response and register slave
// Notes on behaviour
// - Comparator lock limit field, bits 26-23
// - Converter lock threshold field, bits 22-19
// - Modes 0-3 latch fault, drive stage
// - Brakes turn on all high or low transistors
// - Modes 4,5,7 retry, then latch past limit
// - Retry modes keep tristate, recirculation, low brake
// - Mode 6 retries with high brake, fault shown
// - Mode 8 only reports, stage untouched
// - Modes 9-F disable detection entirely
// - Filter time field bits 14-11 selects deglitch
// - Retry wait field selects 100 ms to 14 s
module lcf_top #(
    parameter int TICK_DIV  = lcf_pkg::TICK_CYCLES,
    parameter int RETRY_W   = 3
) (
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    // AHB-Lite slave
    input  wire logic                 HSEL,
    input  wire logic [31:0]          HADDR,
    input  wire logic [1:0]           HTRANS,
    input  wire logic                 HWRITE,
    input  wire logic [2:0]           HSIZE,
    input  wire logic [31:0]          HWDATA,
    input  wire logic                 HREADY,
    output logic                      HREADYOUT,
    output logic [31:0]               HRDATA,
    output logic                      HRESP,
    // Current sense inputs
    input  wire logic                 LOCK_CMP,
    input  wire logic                 LOCK_CONV,
    // Threshold selections to the analog paths
    output logic [3:0]                COMP_LIMIT,
    output logic [3:0]                CONV_LIMIT,
    // Output stage control, fault pin and interrupt
    output lcf_pkg::lcf_gate_type     GATE,
    output logic                      FAULT_INDICATOR_N,
    output logic                      IRQ
);

    typedef enum {ST_IDLE, ST_RETRY_WAIT, ST_LATCHED, ST_REPORT}
        lcf_state_type;

    lcf_pkg::lcf_cfg_type   cfg_r;
    logic [RETRY_W-1:0]     retry_count_limit_r;
    logic [RETRY_W-1:0]     retry_cnt_r;
    logic [2:0]             irq_stat_r;
    logic [2:0]             irq_stat_nxt;
    logic [2:0]             irq_mask_r;
    lcf_state_type          state_r;
    lcf_pkg::lcf_event_type ev;
    logic [lcf_pkg::TW-1:0] deg_cnt_r;
    logic [lcf_pkg::TW-1:0] retry_tmr_r;
    logic [3:0]             mode;
    logic                   lock_cond;
    logic                   detect;
    logic                   deg_tick;
    logic                   retry_tick;
    logic                   retry_done;
    logic                   mode_off;
    logic                   sw_clear;
    logic                   addr_ok;
    logic                   wr_pend_r;
    logic [7:0]             wr_addr_r;
    logic                   rd_stat;
    logic [31:0]            rd_data;
    logic                   fault_n_nxt;
    lcf_pkg::lcf_gate_type  gate_nxt;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Zero wait states: every transfer answers OKAY in its data phase
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign addr_ok   = HSEL && HTRANS[1] && HREADY;
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= addr_ok && HWRITE && HADDR[31:8] == 24'h0;
            wr_addr_r <= HADDR[7:0];
        end
    end
    always_comb
    begin
        rd_data = 32'h0;
        unique case (HADDR[7:0])
            lcf_pkg::CFG_OFS:      rd_data = cfg_r;
            lcf_pkg::RETRY_OFS:    rd_data[RETRY_W-1:0] = retry_count_limit_r;
            lcf_pkg::STATUS_OFS:
            begin
                rd_data[0] = state_r == ST_LATCHED;
                rd_data[1] = state_r == ST_RETRY_WAIT;
                rd_data[2] = state_r == ST_REPORT;
                rd_data[3] = lock_cond;
                rd_data[4] = !FAULT_INDICATOR_N;
                rd_data[8 +: RETRY_W] = retry_cnt_r;
            end
            lcf_pkg::IRQ_STAT_OFS: rd_data[2:0] = irq_stat_r;
            lcf_pkg::IRQ_MASK_OFS: rd_data[2:0] = irq_mask_r;
            default:               rd_data = 32'h0;
        endcase
        if (HADDR[31:8] != 24'h0)
            rd_data = 32'h0;
    end
    // Read data is sampled at the address phase so it sits in a flop
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            HRDATA <= 32'h0;
        else if (addr_ok && !HWRITE)
            HRDATA <= rd_data;
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            cfg_r <= lcf_pkg::CFG_RESET;
        else if (wr_pend_r && wr_addr_r == lcf_pkg::CFG_OFS)
            cfg_r <= HWDATA;
    end
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            retry_count_limit_r <= RETRY_W'(lcf_pkg::RETRY_RESET);
        else if (wr_pend_r && wr_addr_r == lcf_pkg::RETRY_OFS)
            retry_count_limit_r <= HWDATA[RETRY_W-1:0];
    end
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            irq_mask_r <= lcf_pkg::IRQ_RESET;
        else if (wr_pend_r && wr_addr_r == lcf_pkg::IRQ_MASK_OFS)
            irq_mask_r <= HWDATA[2:0];
    end
    assign sw_clear   = wr_pend_r && wr_addr_r == lcf_pkg::RETRY_OFS
                        && HWDATA[lcf_pkg::FAULT_CLR_BIT];
    assign COMP_LIMIT = cfg_r.comparator_lock_current_limit;
    assign CONV_LIMIT = cfg_r.converter_lock_current_limit;
    assign mode       = cfg_r.response_mode;
    assign mode_off   = mode > lcf_pkg::MODE_REPORT;

    // ------------------------------------------------------------------
    // Deglitch filter
    // ------------------------------------------------------------------
    // Either path over its limit counts; a disabled mode sees nothing
    assign lock_cond = (LOCK_CMP || LOCK_CONV) && !mode_off;
    lcf_tick #(
        .DIV     (TICK_DIV)
    ) u_deg_tick (
        .CLK     (CLK),
        .RESETN  (RESETN),
        .restart (!lock_cond || state_r != ST_IDLE),
        .tick    (deg_tick)
    );
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            deg_cnt_r <= '0;
        else if (!lock_cond || state_r != ST_IDLE)
            deg_cnt_r <= '0;
        else if (deg_tick && !detect)
            deg_cnt_r <= deg_cnt_r + 1'b1;
    end
    assign detect = lock_cond && state_r == ST_IDLE
        && deg_cnt_r == lcf_pkg::DEG_TICKS[cfg_r.lock_current_filter_time];

    // ------------------------------------------------------------------
    // Retry wait timer
    // ------------------------------------------------------------------
    lcf_tick #(
        .DIV     (TICK_DIV)
    ) u_retry_tick (
        .CLK     (CLK),
        .RESETN  (RESETN),
        .restart (state_r != ST_RETRY_WAIT),
        .tick    (retry_tick)
    );
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            retry_tmr_r <= '0;
        else if (state_r != ST_RETRY_WAIT)
            retry_tmr_r <= '0;
        else if (retry_tick)
            retry_tmr_r <= retry_tmr_r + 1'b1;
    end
    assign retry_done = state_r == ST_RETRY_WAIT && retry_tick
        && retry_tmr_r == lcf_pkg::RETRY_TICKS[cfg_r.lock_retry_wait] - 1'b1;

    // ------------------------------------------------------------------
    // Response state machine
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            state_r <= ST_IDLE;
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (detect)
                    begin
                        if (mode == lcf_pkg::MODE_REPORT)
                            state_r <= ST_REPORT;
                        else if (mode < lcf_pkg::MODE_FIRST_RETRY)
                            state_r <= ST_LATCHED;
                        else if (retry_cnt_r >= retry_count_limit_r)
                            state_r <= ST_LATCHED;
                        else
                            state_r <= ST_RETRY_WAIT;
                    end
                ST_RETRY_WAIT:
                    if (retry_done || mode_off)
                        state_r <= ST_IDLE;
                ST_LATCHED:
                    if (sw_clear || mode_off)
                        state_r <= ST_IDLE;
                ST_REPORT:
                    if (!lock_cond || mode != lcf_pkg::MODE_REPORT)
                        state_r <= ST_IDLE;
            endcase
        end
    end

    // Retry count survives auto clears so repeated locks hit the limit
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            retry_cnt_r <= '0;
        else if (sw_clear || (state_r == ST_IDLE && detect
                 && (mode < lcf_pkg::MODE_FIRST_RETRY
                     || retry_cnt_r >= retry_count_limit_r)))
            retry_cnt_r <= '0;
        else if (state_r == ST_IDLE && detect
                 && mode < lcf_pkg::MODE_REPORT)
            retry_cnt_r <= retry_cnt_r + 1'b1;
    end

    // ------------------------------------------------------------------
    // Output stage and fault pin
    // ------------------------------------------------------------------
    always_comb
    begin
        gate_nxt    = '0;
        fault_n_nxt = 1'b1;
        if (state_r == ST_LATCHED || state_r == ST_RETRY_WAIT)
        begin
            unique case (mode[1:0])
                lcf_pkg::ACT_TRISTATE: gate_nxt.tristate = 1'b1;
                lcf_pkg::ACT_RECIRC:   gate_nxt.recirc   = 1'b1;
                lcf_pkg::ACT_HS_BRAKE: gate_nxt.hs_on    = 3'h7;
                lcf_pkg::ACT_LS_BRAKE: gate_nxt.ls_on    = 3'h7;
            endcase
        end
        if (state_r == ST_LATCHED || state_r == ST_REPORT)
            fault_n_nxt = 1'b0;
        if (state_r == ST_RETRY_WAIT && mode == lcf_pkg::MODE_HS_RETRY)
            fault_n_nxt = 1'b0;
    end
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            GATE              <= '0;
            FAULT_INDICATOR_N <= 1'b1;
        end
        else
        begin
            GATE              <= gate_nxt;
            FAULT_INDICATOR_N <= fault_n_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status: set wins over the read clear
    // ------------------------------------------------------------------
    assign ev.lock_detected = detect;
    assign ev.fault_latched = state_r != ST_LATCHED
        && ((state_r == ST_IDLE && detect && mode < lcf_pkg::MODE_REPORT
             && (mode < lcf_pkg::MODE_FIRST_RETRY
                 || retry_cnt_r >= retry_count_limit_r)));
    assign ev.retry_cleared = retry_done;
    assign rd_stat = addr_ok && !HWRITE && HADDR == 32'(lcf_pkg::IRQ_STAT_OFS);
    assign irq_stat_nxt = (irq_stat_r & ~{3{rd_stat}}) | ev;
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            irq_stat_r <= lcf_pkg::IRQ_RESET;
        else
            irq_stat_r <= irq_stat_nxt;
    end
    assign IRQ = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_comp_limit_write: assert property (
        @(posedge CLK) disable iff (!RESETN)
        wr_pend_r && wr_addr_r == lcf_pkg::CFG_OFS
        |=> COMP_LIMIT == $past(HWDATA[26:23]))
        else $error("comparator limit not taken from write");
    a_conv_limit_write: assert property (
        @(posedge CLK) disable iff (!RESETN)
        wr_pend_r && wr_addr_r == lcf_pkg::CFG_OFS
        |=> CONV_LIMIT == $past(HWDATA[22:19]))
        else $error("converter limit not taken from write");
    a_latch_direct: assert property (
        @(posedge CLK) disable iff (!RESETN)
        detect && mode < 4'h4 && !sw_clear
        |=> state_r == ST_LATCHED ##1 !FAULT_INDICATOR_N)
        else $error("direct mode did not latch with fault pin");
    a_hs_brake_all: assert property (
        @(posedge CLK) disable iff (!RESETN)
        (state_r == ST_LATCHED && mode == 4'h2)[*2]
        |-> GATE.hs_on == 3'h7 && GATE.ls_on == 3'h0)
        else $error("high-side brake not applied on all phases");
    a_retry_limit: assert property (
        @(posedge CLK) disable iff (!RESETN)
        detect && mode == 4'h5 && retry_cnt_r >= retry_count_limit_r
        |=> state_r == ST_LATCHED && retry_cnt_r == '0)
        else $error("retry limit did not latch the fault");
    a_retry_tristate: assert property (
        @(posedge CLK) disable iff (!RESETN)
        (state_r == ST_RETRY_WAIT && mode == 4'h4)[*2]
        |-> GATE.tristate && FAULT_INDICATOR_N)
        else $error("retry tristate stage wrong");
    a_hs_retry_fault: assert property (
        @(posedge CLK) disable iff (!RESETN)
        (state_r == ST_RETRY_WAIT && mode == 4'h6)[*2]
        |-> !FAULT_INDICATOR_N && GATE.hs_on == 3'h7)
        else $error("high-side retry lacks fault or brake");
    a_report_only: assert property (
        @(posedge CLK) disable iff (!RESETN)
        (state_r == ST_REPORT)[*2] |-> GATE == '0 && !FAULT_INDICATOR_N)
        else $error("report mode touched the output stage");
    a_disabled_idle: assert property (
        @(posedge CLK) disable iff (!RESETN)
        mode > 4'h8 |=> state_r == ST_IDLE || $past(state_r) != ST_IDLE)
        else $error("disabled mode left idle");
    a_filter_restart: assert property (
        @(posedge CLK) disable iff (!RESETN)
        !lock_cond |=> deg_cnt_r == '0 && !detect)
        else $error("filter did not restart on drop");
    a_filter_time: assert property (
        @(posedge CLK) disable iff (!RESETN)
        detect |-> deg_cnt_r ==
            lcf_pkg::DEG_TICKS[cfg_r.lock_current_filter_time])
        else $error("detection before filter time");

endmodule

// file: dv/lcf_motor_model.sv
// Model of a stalled motor as seen by the two current sense paths
module lcf_motor_model (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // Stall requests from the bench
    input  wire logic            stall_cmp,
    input  wire logic            stall_conv,
    // Output stage state
    input  wire lcf_pkg::lcf_gate_type gate,
    // Over-limit flags to the device
    output logic                 over_cmp,
    output logic                 over_conv
);
    timeunit 1ns;
    timeprecision 1ps;

    // A locked rotor draws current only while the stage drives normally;
    // any fault action on the stage removes the current within a cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            over_cmp  <= 1'b0;
            over_conv <= 1'b0;
        end
        else
        begin
            over_cmp  <= stall_cmp && (gate == '0);
            over_conv <= stall_conv && (gate == '0);
        end
    end
endmodule

// file: dv/lcf_top_tb.sv
// Self-checking bench for the lock current fault block
module lcf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0;
    logic                  HWRITE = 1'b0, rd_ph = 1'b0;
    logic                  st_cmp = 1'b0, st_conv = 1'b0;
    logic [31:0]           HADDR = '0, HWDATA = '0, lfsr = 32'hd71b;
    logic [1:0]            HTRANS = '0;
    logic [2:0]            HSIZE = 3'h2;
    logic                  HREADYOUT, HRESP, IRQ, FAULT_INDICATOR_N;
    logic                  LOCK_CMP, LOCK_CONV;
    logic [31:0]           HRDATA;
    logic [3:0]            COMP_LIMIT, CONV_LIMIT;
    lcf_pkg::lcf_gate_type GATE;
    logic [31:0]           rd_q[$];
    logic [9:0]            pin_q[$];
    int                    n_fail = 0, num_checks = 0, cyc = 0;

    always #5 CLK = ~CLK;

    lcf_top #(.TICK_DIV(4), .RETRY_W(3)) dut (
        .CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA),
        .HRESP(HRESP), .LOCK_CMP(LOCK_CMP), .LOCK_CONV(LOCK_CONV),
        .COMP_LIMIT(COMP_LIMIT), .CONV_LIMIT(CONV_LIMIT), .GATE(GATE),
        .FAULT_INDICATOR_N(FAULT_INDICATOR_N), .IRQ(IRQ));

    lcf_motor_model motor (
        .clk(CLK), .resetn(RESETN), .stall_cmp(st_cmp),
        .stall_conv(st_conv), .gate(GATE), .over_cmp(LOCK_CMP),
        .over_conv(LOCK_CONV));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Whole run holds two retry waits of 8000 cycles, one per retry test, plus traffic
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            test_done;
        end
    end

    // Read data is taken at the edge that ends its data phase
    always @(posedge CLK)
        if (rd_ph && HREADYOUT === 1'b1)
            chk(HRDATA, rd_q.pop_front());

    // Pin notes are compared where the outputs have settled
    always @(negedge CLK)
        while (pin_q.size() > 0)
            chk({21'h0, HRESP, GATE, FAULT_INDICATOR_N, IRQ},
                {22'h0, pin_q.pop_front()});

    // ------------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [7:0] gexp(input logic [3:0] m);
        return m[1] ? (m[0] ? 8'h07 : 8'h38) : (m[0] ? 8'h40 : 8'h80);
    endfunction

    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge CLK);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HADDR  <= {24'h0, a};
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rd_ph  <= !w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd_ph  <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(a, 1'b0, 32'h0);
    endtask

    task pins(input logic [7:0] g, input logic f, input logic i);
        pin_q.push_back({g, f, i});
        @(posedge CLK);
    endtask

    task wait_n(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task wait_fault(input int lim, output int k);
        k = 0;
        while (FAULT_INDICATOR_N !== 1'b0 && k < lim)
        begin
            @(posedge CLK);
            k++;
        end
        chk({31'h0, k < lim}, 32'h1);
    endtask

    // Random current limits, chosen mode and filter code
    task set_cfg(input logic [3:0] mode, input logic [3:0] filt);
        logic [31:0] c;
        lfsr = nxt(lfsr);
        c = (lfsr & 32'h07f8_0000) | {13'h0, mode, filt, 11'h0};
        wr(lcf_pkg::CFG_OFS, c);
        rd(lcf_pkg::CFG_OFS, c);
        chk({28'h0, COMP_LIMIT}, {28'h0, c[26:23]});
        chk({28'h0, CONV_LIMIT}, {28'h0, c[22:19]});
    endtask

    task clear_fault;
        st_cmp  <= 1'b0;
        st_conv <= 1'b0;
        wr(lcf_pkg::RETRY_OFS, 32'h100);
        wait_n(3);
        pins(8'h0, 1'b1, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int k;
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        pins(8'h0, 1'b1, 1'b0);
        rd(lcf_pkg::CFG_OFS, 32'h0);
        rd(lcf_pkg::RETRY_OFS, 32'h0);
        rd(lcf_pkg::IRQ_MASK_OFS, 32'h0);
        rd(8'h40, 32'h0);
        wr(lcf_pkg::IRQ_MASK_OFS, 32'h7);
        // Latching modes, and retry modes with a zero retry limit
        for (int i = 0; i < 8; i++)
            if (i != 6)
            begin
                set_cfg(i[3:0], 4'h0);
                st_cmp  <= i[0];
                st_conv <= !i[0];
                wait_fault(50, k);
                pins(gexp(i[3:0]), 1'b0, 1'b1);
                rd(lcf_pkg::IRQ_STAT_OFS, 32'h3);
                pins(gexp(i[3:0]), 1'b0, 1'b0);
                clear_fault;
            end
        // One retry, then the next detection latches
        wr(lcf_pkg::RETRY_OFS, 32'h1);
        set_cfg(4'h4, 4'h0);
        st_cmp <= 1'b1;
        wait_n(12);
        pins(8'h80, 1'b1, 1'b1);
        rd(lcf_pkg::STATUS_OFS, 32'h102);
        wait_fault(9000, k);
        chk({31'h0, k > 7000}, 32'h1);
        pins(8'h80, 1'b0, 1'b1);
        rd(lcf_pkg::IRQ_STAT_OFS, 32'h7);
        rd(lcf_pkg::STATUS_OFS, 32'h11);
        clear_fault;
        // High-side brake retry, released after 8000 cycles
        wr(lcf_pkg::RETRY_OFS, 32'h1);
        set_cfg(4'h6, 4'h0);
        st_conv <= 1'b1;
        wait_fault(50, k);
        pins(8'h38, 1'b0, 1'b1);
        st_conv <= 1'b0;
        rd(lcf_pkg::IRQ_STAT_OFS, 32'h1);
        wait_n(7800);
        pins(8'h38, 1'b0, 1'b0);
        wait_n(300);
        pins(8'h0, 1'b1, 1'b1);
        rd(lcf_pkg::IRQ_STAT_OFS, 32'h4);
        // Limit used up: the next detection latches with the brake on
        st_conv <= 1'b1;
        wait_fault(50, k);
        pins(8'h38, 1'b0, 1'b1);
        rd(lcf_pkg::STATUS_OFS, 32'h11);
        rd(lcf_pkg::IRQ_STAT_OFS, 32'h3);
        clear_fault;
        // Report only
        set_cfg(4'h8, 4'h0);
        st_cmp <= 1'b1;
        wait_fault(50, k);
        pins(8'h0, 1'b0, 1'b1);
        rd(lcf_pkg::IRQ_STAT_OFS, 32'h1);
        rd(lcf_pkg::STATUS_OFS, 32'h1c);
        st_cmp <= 1'b0;
        wait_n(5);
        pins(8'h0, 1'b1, 1'b0);
        // Disabled codes
        for (int i = 9; i < 16; i++)
        begin
            set_cfg(i[3:0], 4'h0);
            st_cmp <= 1'b1;
            wait_n(20);
            pins(8'h0, 1'b1, 1'b0);
            st_cmp <= 1'b0;
        end
        rd(lcf_pkg::IRQ_STAT_OFS, 32'h0);
        // Two-tick filter: a short pulse is dropped, a long one is counted
        set_cfg(4'h0, 4'h1);
        st_cmp <= 1'b1;
        wait_n(5);
        st_cmp <= 1'b0;
        wait_n(20);
        pins(8'h0, 1'b1, 1'b0);
        st_cmp <= 1'b1;
        wait_fault(50, k);
        chk({31'h0, k >= 8 && k <= 14}, 32'h1);
        pins(8'h80, 1'b0, 1'b1);
        rd(lcf_pkg::IRQ_STAT_OFS, 32'h3);
        clear_fault;
        test_done;
    end
endmodule
